// ### design/timer_pkg.sv
package timer_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int PRESC_W = 5;
    localparam logic [15:0] ADDR_CTRL = 16'hffb6;
    localparam logic [15:0] ADDR_STAT = 16'hffb7;
    localparam logic [15:0] ADDR_CNT_H = 16'hffb8;
    localparam logic [15:0] ADDR_CNT_L = 16'hffb9;
    localparam logic [15:0] ADDR_CMP_H = 16'hffba;
    localparam logic [15:0] ADDR_CMP_L = 16'hffbb;
    localparam logic [15:0] ADDR_MSTOP = 16'hfffa;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'hff;
    localparam logic [7:0] MSTOP_RESET = 8'hff;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] WO_READ = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] FLAG_MASK = 8'hcc;
    localparam int CTRL_HIGH_TOGGLE_LEVEL = 7;
    localparam int CTRL_HTOP = 6;
    localparam int CTRL_HSEL_LSB = 4;
    localparam int CTRL_LOW_TOGGLE_LEVEL = 3;
    localparam int ST_HIGH_OVERFLOW_FLAG = 7;
    localparam int ST_HIGH_MATCH_FLAG = 6;
    localparam int ST_HIGH_OVERFLOW_IRQ_ENABLE = 5;
    localparam int ST_CLRH = 4;
    localparam int ST_LOW_OVERFLOW_FLAG = 3;
    localparam int ST_LOW_MATCH_FLAG = 2;
    localparam int ST_LOW_OVERFLOW_IRQ_ENABLE = 1;
    localparam int ST_CLRL = 0;
    localparam int MSTOP_TIMER = 2;
    localparam logic [PRESC_W-1:0] DIV32_END = 5'h1f;
    localparam logic [3:0] DIV16_END = 4'hf;
    localparam logic [1:0] DIV4_END = 2'h3;
    localparam logic [1:0] SUB4_END = 2'h3;
    localparam logic [1:0] SUB_RESET = 2'h0;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 5'h00;
    typedef enum logic [2:0] {
        CKS_EVENT0 = 3'h0,
        CKS_EVENT1 = 3'h1,
        CKS_EVENT2 = 3'h2,
        CKS_NONE = 3'h3,
        CKS_DIV32 = 3'h4,
        CKS_DIV16 = 3'h5,
        CKS_DIV4 = 3'h6,
        CKS_SUB4 = 3'h7
    } clk_sel_t;
endpackage

// ### design/timer_src_if.sv
`timescale 1ns/100ps
interface timer_src_if;
    timer_pkg::clk_sel_t sel;
    logic tick;
    modport ctrl(output sel, input tick);
    modport mux(input sel, output tick);
endinterface

// ### design/count_source.sv
`timescale 1ns/100ps
module count_source #(
    parameter bit HAS_EVENT = 1'b1
) (
    timer_src_if.mux src,
    input wire logic div32_i,
    input wire logic div16_i,
    input wire logic div4_i,
    input wire logic sub4_i,
    input wire logic event_i,
    input wire logic low_power_i
);
    import timer_pkg::*;
    // in low-power modes only the subclock source keeps running
    always_comb begin
        src.tick = 1'b0;
        unique case (src.sel)
            CKS_EVENT0, CKS_EVENT1, CKS_EVENT2: src.tick = HAS_EVENT && event_i && !low_power_i;
            CKS_NONE: src.tick = 1'b0;
            CKS_DIV32: src.tick = div32_i && !low_power_i;
            CKS_DIV16: src.tick = div16_i && !low_power_i;
            CKS_DIV4: src.tick = div4_i && !low_power_i;
            CKS_SUB4: src.tick = sub4_i;
        endcase
    end
endmodule // count_source

// ### design/temp_latch.sv
`timescale 1ns/100ps
module temp_latch (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [timer_pkg::DATA_W-1:0] d_i,
    output logic [timer_pkg::DATA_W-1:0] q_o
);
    import timer_pkg::*;
    // byte holding latch for split 16-bit transfers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_o <= TEMP_RESET;
        end else if (ce_i && load_i) begin
            q_o <= d_i;
        end
    end
endmodule // temp_latch

// ### design/dual_mode_compare_timer.sv
`timescale 1ns/100ps
module dual_mode_compare_timer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [timer_pkg::ADDR_W-1:0] addr_i,
    input wire logic [timer_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [timer_pkg::DATA_W-1:0] rdata_o,
    input wire logic sub_tick_i,
    input wire logic low_power_i,
    input wire logic event_input_pin_i,
    input wire logic event_rising_i,
    input wire logic high_irq_enable_i,
    input wire logic low_irq_enable_i,
    input wire logic high_irq_clear_i,
    input wire logic low_irq_clear_i,
    output logic high_toggle_pin_o,
    output logic low_toggle_pin_o,
    output logic high_irq_request_o,
    output logic low_irq_request_o,
    output logic high_irq_o,
    output logic low_irq_o
);
    import timer_pkg::*;

    logic [7:0] ctrl_reg;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] arm_reg;
    logic [7:0] mstop_reg;
    logic [7:0] cnt_h_reg;
    logic [7:0] cnt_l_reg;
    logic [7:0] cmp_h_reg;
    logic [7:0] cmp_l_reg;
    logic [7:0] temp_q;
    logic [7:0] temp_d;
    logic [PRESC_W-1:0] presc_reg;
    logic [1:0] sub_reg;
    logic evt_prev_reg;
    logic mh_prev_reg;
    logic ml_prev_reg;
    logic hreq_next;
    logic lreq_next;

    timer_src_if src_l ();
    timer_src_if src_h ();

    // register decode
    logic wr_ctrl, wr_stat, wr_ch, wr_cl, wr_mh, wr_ml, wr_mstop, rd_stat, rd_ch;
    assign wr_ctrl = ce_i && wr_i && (addr_i == ADDR_CTRL);
    assign wr_stat = ce_i && wr_i && (addr_i == ADDR_STAT);
    assign wr_ch = ce_i && wr_i && (addr_i == ADDR_CNT_H);
    assign wr_cl = ce_i && wr_i && (addr_i == ADDR_CNT_L);
    assign wr_mh = ce_i && wr_i && (addr_i == ADDR_CMP_H);
    assign wr_ml = ce_i && wr_i && (addr_i == ADDR_CMP_L);
    assign wr_mstop = ce_i && wr_i && (addr_i == ADDR_MSTOP);
    assign rd_stat = ce_i && rd_i && (addr_i == ADDR_STAT);
    assign rd_ch = ce_i && rd_i && (addr_i == ADDR_CNT_H);

    logic run, wide;
    assign run = ce_i && mstop_reg[MSTOP_TIMER];
    assign wide = !ctrl_reg[CTRL_HTOP];

    // shared prescaler and subclock divider
    logic div32, div16, div4, sub4, evt_edge;
    assign div32 = (presc_reg == DIV32_END);
    assign div16 = (presc_reg[3:0] == DIV16_END);
    assign div4 = (presc_reg[1:0] == DIV4_END);
    assign sub4 = sub_tick_i && (sub_reg == SUB4_END);
    assign evt_edge = event_rising_i ? (event_input_pin_i && !evt_prev_reg) : (!event_input_pin_i && evt_prev_reg);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_reg <= PRESC_RESET;
            sub_reg <= SUB_RESET;
            evt_prev_reg <= 1'b0;
        end else if (ce_i) begin
            presc_reg <= presc_reg + 5'h01;
            evt_prev_reg <= event_input_pin_i;
            if (sub_tick_i) begin
                sub_reg <= sub_reg + 2'h1;
            end
        end
    end

    assign src_l.sel = clk_sel_t'(ctrl_reg[2:0]);
    assign src_h.sel = clk_sel_t'(ctrl_reg[CTRL_HSEL_LSB+2:CTRL_HSEL_LSB]);

    count_source #(.HAS_EVENT(1'b1)) u_src_l (
        .src(src_l.mux),
        .div32_i(div32),
        .div16_i(div16),
        .div4_i(div4),
        .sub4_i(sub4),
        .event_i(evt_edge),
        .low_power_i(low_power_i)
    );

    count_source #(.HAS_EVENT(1'b0)) u_src_h (
        .src(src_h.mux),
        .div32_i(div32),
        .div16_i(div16),
        .div4_i(div4),
        .sub4_i(sub4),
        .event_i(1'b0),
        .low_power_i(low_power_i)
    );

    // count, compare, clear and overflow events
    logic tick_l, tick_h, match_h, match_l, wclr, hclr8, lclr8, ovf_h, ovf_l, mh_ev, ml_ev;
    assign tick_l = src_l.tick && run;
    assign match_h = wide ? ({cnt_h_reg, cnt_l_reg} == {cmp_h_reg, cmp_l_reg}) : (cnt_h_reg == cmp_h_reg);
    assign match_l = !wide && (cnt_l_reg == cmp_l_reg);
    assign wclr = wide && tick_l && match_h && stat_reg[ST_CLRH];
    assign tick_h = wide ? (tick_l && (cnt_l_reg == CNT_MAX) && !wclr) : (src_h.tick && run);
    assign hclr8 = !wide && tick_h && match_h && stat_reg[ST_CLRH];
    assign lclr8 = !wide && tick_l && match_l && stat_reg[ST_CLRL];
    assign ovf_h = tick_h && (cnt_h_reg == CNT_MAX) && !hclr8;
    assign ovf_l = !wide && tick_l && (cnt_l_reg == CNT_MAX) && !lclr8;
    assign mh_ev = run && match_h && !mh_prev_reg;
    assign ml_ev = run && match_l && !ml_prev_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mh_prev_reg <= 1'b0;
            ml_prev_reg <= 1'b0;
        end else if (run) begin
            mh_prev_reg <= match_h;
            ml_prev_reg <= match_l;
        end
    end

    // byte holding latch: upper write captured, or lower half kept on upper read
    assign temp_d = rd_ch ? cnt_l_reg : wdata_i;
    temp_latch u_temp (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .load_i(wide && (wr_ch || wr_mh || rd_ch)),
        .d_i(temp_d),
        .q_o(temp_q)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_l_reg <= CNT_RESET;
        end else if (wr_cl) begin
            cnt_l_reg <= wdata_i;
        end else if (wclr || lclr8) begin
            cnt_l_reg <= CNT_RESET;
        end else if (tick_l) begin
            cnt_l_reg <= cnt_l_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_h_reg <= CNT_RESET;
        end else if (wr_cl && wide) begin
            cnt_h_reg <= temp_q;
        end else if (wr_ch && !wide) begin
            cnt_h_reg <= wdata_i;
        end else if (wclr || hclr8) begin
            cnt_h_reg <= CNT_RESET;
        end else if (tick_h) begin
            cnt_h_reg <= cnt_h_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_h_reg <= CMP_RESET;
            cmp_l_reg <= CMP_RESET;
        end else begin
            if (wr_ml && wide) begin
                cmp_h_reg <= temp_q;
            end else if (wr_mh && !wide) begin
                cmp_h_reg <= wdata_i;
            end
            if (wr_ml) begin
                cmp_l_reg <= wdata_i;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mstop_reg <= MSTOP_RESET;
        end else if (wr_mstop) begin
            mstop_reg <= wdata_i;
        end
    end

    // status flags: software can only clear an armed flag, hardware set wins
    always_comb begin
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = (stat_reg & FLAG_MASK & ~(arm_reg & ~wdata_i)) | (wdata_i & ~FLAG_MASK);
        end
        if (ovf_h) begin
            stat_next[ST_HIGH_OVERFLOW_FLAG] = 1'b1;
        end
        if (mh_ev) begin
            stat_next[ST_HIGH_MATCH_FLAG] = 1'b1;
        end
        if (ovf_l) begin
            stat_next[ST_LOW_OVERFLOW_FLAG] = 1'b1;
        end
        if (ml_ev) begin
            stat_next[ST_LOW_MATCH_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_reg <= STAT_RESET;
        end else if (ce_i) begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arm_reg <= STAT_RESET;
        end else if (rd_stat) begin
            arm_reg <= stat_reg & FLAG_MASK;
        end else if (wr_stat) begin
            arm_reg <= STAT_RESET;
        end
    end

    // interrupt request flags and gated requests
    assign hreq_next = mh_ev || (ovf_h && stat_reg[ST_HIGH_OVERFLOW_IRQ_ENABLE]) || (high_irq_request_o && !high_irq_clear_i);
    assign lreq_next = ml_ev || (ovf_l && stat_reg[ST_LOW_OVERFLOW_IRQ_ENABLE]) || (low_irq_request_o && !low_irq_clear_i);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_irq_request_o <= 1'b0;
            low_irq_request_o <= 1'b0;
            high_irq_o <= 1'b0;
            low_irq_o <= 1'b0;
        end else if (ce_i) begin
            high_irq_request_o <= hreq_next;
            low_irq_request_o <= lreq_next;
            high_irq_o <= high_irq_request_o && high_irq_enable_i;
            low_irq_o <= low_irq_request_o && low_irq_enable_i;
        end
    end

    // toggle outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_toggle_pin_o <= 1'b0;
            low_toggle_pin_o <= 1'b0;
        end else if (wr_ctrl) begin
            high_toggle_pin_o <= wdata_i[CTRL_HIGH_TOGGLE_LEVEL];
            low_toggle_pin_o <= wdata_i[CTRL_LOW_TOGGLE_LEVEL];
        end else begin
            if (mh_ev) begin
                high_toggle_pin_o <= !high_toggle_pin_o;
            end
            if (ml_ev) begin
                low_toggle_pin_o <= !low_toggle_pin_o;
            end
        end
    end

    // read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= UNMAPPED_READ;
        end else if (ce_i && rd_i) begin
            unique case (addr_i)
                ADDR_CTRL: rdata_o <= WO_READ;
                ADDR_STAT: rdata_o <= stat_reg;
                ADDR_CNT_H: rdata_o <= cnt_h_reg;
                ADDR_CNT_L: rdata_o <= wide ? temp_q : cnt_l_reg;
                ADDR_CMP_H: rdata_o <= cmp_h_reg;
                ADDR_CMP_L: rdata_o <= cmp_l_reg;
                ADDR_MSTOP: rdata_o <= mstop_reg;
                default: rdata_o <= UNMAPPED_READ;
            endcase
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    reset_values_a: assert property ($rose(resetn_i) |-> cnt_h_reg == CNT_RESET && cmp_l_reg == CMP_RESET)
        else $error("counter or compare not at reset value");
    wide_overflow_a: assert property (wide && tick_l && {cnt_h_reg, cnt_l_reg} == {CNT_MAX, CNT_MAX} && !wclr && !wr_cl
        |=> stat_reg[ST_HIGH_OVERFLOW_FLAG] && cnt_h_reg == CNT_RESET)
        else $error("16-bit wrap did not set high overflow");
    low_overflow_a: assert property (ovf_l && stat_reg[ST_LOW_OVERFLOW_IRQ_ENABLE] |=> stat_reg[ST_LOW_OVERFLOW_FLAG] && low_irq_request_o)
        else $error("low wrap did not set flag and request");
    match_request_a: assert property ($rose(match_h) && run |=> stat_reg[ST_HIGH_MATCH_FLAG] && high_irq_request_o)
        else $error("match did not set flag and request");
    irq_gate_a: assert property (!high_irq_enable_i || !high_irq_request_o |=> !high_irq_o)
        else $error("interrupt without request and enable");
    level_write_a: assert property (wr_ctrl |=> high_toggle_pin_o == $past(wdata_i[CTRL_HIGH_TOGGLE_LEVEL]))
        else $error("toggle pin not at written level");
    match_toggle_a: assert property (ml_ev && !wr_ctrl |=> low_toggle_pin_o != $past(low_toggle_pin_o))
        else $error("match did not invert low toggle pin");
    flag_no_set_a: assert property (!stat_reg[ST_HIGH_OVERFLOW_FLAG] && !ovf_h |=> !stat_reg[ST_HIGH_OVERFLOW_FLAG])
        else $error("overflow flag set without overflow");
    match_clear_a: assert property (lclr8 && !wr_cl |=> cnt_l_reg == CNT_RESET)
        else $error("low match did not clear counter");
    latch_commit_a: assert property (wide && wr_ch ##1 wr_cl && !wr_ch
        |=> cnt_h_reg == $past(wdata_i, 2) && cnt_l_reg == $past(wdata_i))
        else $error("16-bit write not committed as a pair");
    standby_hold_a: assert property (!mstop_reg[MSTOP_TIMER] && !wr_i |=> $stable(cnt_l_reg) && $stable(cnt_h_reg))
        else $error("counter moved in standby");
endmodule // dual_mode_compare_timer

// ### test/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
    input wire logic clk_i,
    output logic [timer_pkg::ADDR_W-1:0] addr_o,
    output logic [timer_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [timer_pkg::DATA_W-1:0] rdata_i
);
    import timer_pkg::*;
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one byte per access over the narrow bus; released lines show the inverse
    task automatic write8(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic read8(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
    // wide accesses always take the upper byte first; writes go back to back
    task automatic write16(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d[15:8];
        wr_o <= 1'b1;
        @(posedge clk_i);
        addr_o <= a + 16'h0001;
        wdata_o <= d[7:0];
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d[7:0];
    endtask
    task automatic read16(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        read8(a, d[15:8]);
        read8(a + 16'h0001, d[7:0]);
    endtask
endmodule // cpu_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import timer_pkg::*;
    logic clk, resetn, ev_pin, ev_rise, low_power, sub_tick, hie, lie, hclr, lclr;
    logic htog, ltog, hreq, lreq, hirq, lirq, wr, rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [2:0] sub_cnt;
    int failures, checks_done;
    cpu_model cpu (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    dual_mode_compare_timer uut (
        .clk_i(clk), .resetn_i(resetn), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .sub_tick_i(sub_tick), .low_power_i(low_power), .event_input_pin_i(ev_pin),
        .event_rising_i(ev_rise), .high_irq_enable_i(hie), .low_irq_enable_i(lie), .high_irq_clear_i(hclr),
        .low_irq_clear_i(lclr), .high_toggle_pin_o(htog), .low_toggle_pin_o(ltog), .high_irq_request_o(hreq),
        .low_irq_request_o(lreq), .high_irq_o(hirq), .low_irq_o(lirq)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // subclock pulse every 8 system cycles
    always @(posedge clk) begin
        if (!resetn) begin
            sub_cnt <= 3'h0;
            sub_tick <= 1'b0;
        end else begin
            sub_cnt <= sub_cnt + 3'h1;
            sub_tick <= (sub_cnt == 3'h7);
        end
    end
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_range(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic expect16(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] v;
        cpu.read16(a, v);
        check8(v[15:8], e[15:8]);
        check8(v[7:0], e[7:0]);
    endtask
    task automatic wait_req(input bit high, input int limit);
        int n;
        n = 0;
        while (((high ? hreq : lreq) !== 1'b1) && n < limit) begin
            @(posedge clk);
            n++;
        end
        #1;
        check8({7'h00, high ? hreq : lreq}, 8'h01);
        if (n >= limit) begin
            conclude();
        end
    endtask
    task automatic pulse_events(input int n);
        repeat (n) begin
            @(posedge clk) ev_pin <= 1'b1;
            repeat (3) @(posedge clk);
            ev_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        tick(2);
    endtask
    task automatic clr_irq();
        @(posedge clk);
        hclr <= 1'b1;
        lclr <= 1'b1;
        @(posedge clk);
        hclr <= 1'b0;
        lclr <= 1'b0;
        tick(2);
        check8({4'h0, hreq, hirq, lreq, lirq}, 8'h00);
    endtask
    task automatic test_reset();
        logic [7:0] d;
        cpu.read8(ADDR_CTRL, d);
        check8(d, WO_READ);
        cpu.read8(ADDR_STAT, d);
        check8(d, STAT_RESET);
        expect16(ADDR_CNT_H, 16'h0000);
        expect16(ADDR_CMP_H, 16'hffff);
        cpu.read8(ADDR_MSTOP, d);
        check8(d, MSTOP_RESET);
        cpu.read8(16'hffbc, d);
        check8(d, UNMAPPED_READ);
        check8({6'h00, htog, ltog}, 8'h00);
        done("reset");
    endtask
    task automatic test_wide();
        cpu.write16(ADDR_CNT_H, 16'haa55);
        expect16(ADDR_CNT_H, 16'haa55);
        cpu.write8(ADDR_CNT_H, 8'h12);
        expect16(ADDR_CNT_H, 16'haa55);
        cpu.write16(ADDR_CMP_H, 16'h1234);
        expect16(ADDR_CMP_H, 16'h1234);
        done("wide");
    endtask
    task automatic test_cascade();
        logic [7:0] d;
        cpu.write16(ADDR_CNT_H, 16'h00fe);
        pulse_events(3);
        expect16(ADDR_CNT_H, 16'h0101);
        cpu.read8(ADDR_STAT, d);
        check8(d & 8'h08, 8'h00);
        cpu.write8(ADDR_CTRL, 8'h01);
        @(posedge clk) ev_rise <= 1'b0;
        pulse_events(1);
        expect16(ADDR_CNT_H, 16'h0102);
        @(posedge clk) ev_rise <= 1'b1;
        done("cascade");
    endtask
    task automatic test_overflow();
        logic [7:0] d;
        cpu.write8(ADDR_STAT, 8'h20);
        cpu.write16(ADDR_CNT_H, 16'hffff);
        pulse_events(1);
        wait_req(1'b1, 20);
        cpu.read8(ADDR_STAT, d);
        check8(d, 8'ha0);
        check8({7'h00, hirq}, 8'h00);
        @(posedge clk) hie <= 1'b1;
        tick(3);
        check8({7'h00, hirq}, 8'h01);
        cpu.write8(ADDR_STAT, 8'h20);
        cpu.write8(ADDR_STAT, 8'ha0);
        cpu.read8(ADDR_STAT, d);
        check8(d, 8'h20);
        clr_irq();
        done("overflow");
    endtask
    task automatic test_match();
        logic [7:0] d;
        cpu.write8(ADDR_CTRL, 8'h80);
        tick(1);
        check8({7'h00, htog}, 8'h01);
        cpu.write8(ADDR_STAT, 8'h10);
        cpu.write16(ADDR_CMP_H, 16'h0102);
        cpu.write16(ADDR_CNT_H, 16'h0100);
        pulse_events(2);
        wait_req(1'b1, 20);
        check8({7'h00, htog}, 8'h00);
        cpu.read8(ADDR_STAT, d);
        check8(d, 8'h50);
        pulse_events(1);
        expect16(ADDR_CNT_H, 16'h0000);
        clr_irq();
        done("match");
    endtask
    task automatic measure(input logic [2:0] code, input logic lp, input logic [7:0] e);
        logic [15:0] v;
        @(posedge clk) low_power <= lp;
        cpu.write8(ADDR_CTRL, {1'b0, code, 1'b0, code});
        cpu.write16(ADDR_CNT_H, 16'h0000);
        repeat (124) @(posedge clk);
        cpu.read16(ADDR_CNT_H, v);
        check_range(v[15:8], (e == 8'h00) ? 8'h00 : e - 8'h01, (e == 8'h00) ? 8'h00 : e + 8'h01);
        check_range(v[7:0], (e == 8'h00) ? 8'h00 : e - 8'h01, (e == 8'h00) ? 8'h00 : e + 8'h01);
    endtask
    task automatic test_rates();
        logic [2:0] codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h3};
        logic [7:0] rate [5] = '{8'h04, 8'h08, 8'h20, 8'h04, 8'h00};
        cpu.write8(ADDR_STAT, 8'h00);
        cpu.write16(ADDR_CMP_H, 16'hffff);
        for (int i = 0; i < 5; i++) begin
            measure(codes[i], 1'b0, rate[i]);
            measure(codes[i], 1'b1, (codes[i] == 3'h7) ? rate[i] : 8'h00);
        end
        cpu.write8(ADDR_MSTOP, 8'hfb);
        measure(3'h6, 1'b0, 8'h00);
        cpu.write8(ADDR_MSTOP, MSTOP_RESET);
        done("rates");
    endtask
    task automatic test_low();
        logic [7:0] d;
        cpu.write8(ADDR_CTRL, 8'h4e);
        tick(1);
        check8({7'h00, ltog}, 8'h01);
        cpu.write8(ADDR_STAT, 8'h03);
        cpu.write8(ADDR_CMP_L, 8'h05);
        cpu.write8(ADDR_CNT_L, 8'h00);
        wait_req(1'b0, 64);
        check8({7'h00, ltog}, 8'h00);
        cpu.read8(ADDR_STAT, d);
        check8(d & 8'h0f, 8'h07);
        cpu.read8(ADDR_CNT_L, d);
        check_range(d, 8'h00, 8'h05);
        cpu.write8(ADDR_STAT, 8'h02);
        cpu.write8(ADDR_CMP_L, 8'h80);
        cpu.write8(ADDR_CNT_L, 8'hfa);
        clr_irq();
        @(posedge clk) lie <= 1'b1;
        tick(40);
        cpu.read8(ADDR_STAT, d);
        check8(d & 8'h08, 8'h08);
        check8({7'h00, lirq}, 8'h01);
        clr_irq();
        done("low half");
    endtask
    initial begin
        failures = 0;
        checks_done = 0;
        resetn = 1'b0;
        ev_pin = 1'b0;
        low_power = 1'b0;
        hie = 1'b0;
        lie = 1'b0;
        hclr = 1'b0;
        lclr = 1'b0;
        ev_rise = 1'b1;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        test_reset();
        test_wide();
        test_cascade();
        test_overflow();
        test_match();
        test_rates();
        test_low();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule // testbench
